//--- hw/mrd_regs.svh
/*
  Address map, geometry and size constants of the memory region decoder.
  Assumes a 32-bit byte address and a single system clock domain.
*/
`ifndef MRD_REGS_SVH
`define MRD_REGS_SVH

`define MRD_CODE_LO     32'h0000_0000
`define MRD_CODE_HI     32'h1FFF_FFFF
`define MRD_ASRAM_LO    32'h2000_0000
`define MRD_ASRAM_HI    32'h3FFF_FFFF
`define MRD_PERIPH_LO   32'h4000_0000
`define MRD_PERIPH_HI   32'h5FFF_FFFF
`define MRD_XRAM_LO     32'h6000_0000
`define MRD_XRAM_HI     32'h9FFF_FFFF
`define MRD_XDEV_LO     32'hA000_0000
`define MRD_XDEV_HI     32'hDFFF_FFFF
`define MRD_SYS_LO      32'hE000_0000
`define MRD_SYS_HI      32'hFFFF_FFFF
`define MRD_ROM_LO      32'h0000_0000
`define MRD_ROM_HI      32'h0001_FFFF
`define MRD_SRAM_LO     32'h0800_0000
`define MRD_SRAM_HI     32'h0804_7FFF
`define MRD_AFLASH_LO   32'h1000_0000
`define MRD_AFLASH_HI   32'h100F_FFFF
`define MRD_AUX_LO      32'h1400_0000
`define MRD_AUX_HI      32'h1400_7FFF
`define MRD_SUP_LO      32'h1600_0000
`define MRD_SUP_HI      32'h1600_7FFF

`define MRD_SECTOR_LSB  18
`define MRD_ROW_LSB     9
`define MRD_WORD_LSB    4
`define MRD_SRAM_BLK_LSB 15
`define MRD_SRAM_BLOCKS 9
`define MRD_CACHE_BYTES 8192
`define MRD_CACHE_WAYS  4
`define MRD_FUSE_BITS   1024
`define MRD_FUSE_SYS    512
`define MRD_BOOT_CTX    3'h0

`endif

//--- hw/mrd_pkg.sv
/*
  Types shared by the memory region decoder modules.
  Assumes mrd_regs.svh supplies the numeric constants.
*/
package mrd_pkg;

  typedef enum logic [1:0] {
    MRD_M_MAIN   = 2'h0,
    MRD_M_SECOND = 2'h1,
    MRD_M_DMA    = 2'h2,
    MRD_M_DEBUG  = 2'h3
  } mrd_master_t;

  typedef enum logic [8:0] {
    MRD_T_NONE   = 9'h000,
    MRD_T_ROM    = 9'h001,
    MRD_T_SRAM   = 9'h002,
    MRD_T_AFLASH = 9'h004,
    MRD_T_AUX    = 9'h008,
    MRD_T_SUP    = 9'h010,
    MRD_T_PERIPH = 9'h020,
    MRD_T_XRAM   = 9'h040,
    MRD_T_SYS    = 9'h080,
    MRD_T_ERR    = 9'h100
  } mrd_target_t;

endpackage

//--- hw/mrd_fuse.sv
/*
  One-time-programmable fuse array, one bit set per program pulse.
  Assumes program and read requests come from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mrd_regs.svh"
module mrd_fuse
  import mrd_pkg::*;
#(
  parameter int BITS = `MRD_FUSE_BITS,
  parameter int SYS  = `MRD_FUSE_SYS
) (
  input  wire logic                    clock,
  input  wire logic                    arst_n,
  input  wire logic                    prog_req,
  input  wire logic [$clog2(BITS)-1:0] idx,
  output logic                         bit_q,
  output logic                         sys_area_q
);

  // Reset models the unblown state; a real array holds its value without power
  logic [BITS-1:0] fuse_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fuse_q <= '0;
    end else if (prog_req) begin
      fuse_q[idx] <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bit_q      <= 1'b0;
      sys_area_q <= 1'b0;
    end else begin
      bit_q      <= fuse_q[idx];
      sys_area_q <= (32'(idx) < SYS);
    end
  end

  property p_fuse_sticky;
    @(posedge clock) disable iff (!arst_n)
      fuse_q[idx] |=> fuse_q[$past(idx)];
  endproperty
  a_fuse_sticky: assert property (p_fuse_sticky) else $error("blown fuse returned to 0");

  property p_fuse_single;
    @(posedge clock) disable iff (!arst_n)
      prog_req |=> ($countones(fuse_q ^ $past(fuse_q)) <= 1);
  endproperty
  a_fuse_single: assert property (p_fuse_single) else $error("more than one fuse changed");

endmodule
`default_nettype wire

//--- hw/mrd_cache.sv
/*
  Tag store of one per-core flash cache, set-associative, round-robin fill.
  Assumes lookups carry a flash address; data lines live outside this block.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mrd_regs.svh"
module mrd_cache
  import mrd_pkg::*;
#(
  parameter int BYTES = `MRD_CACHE_BYTES,
  parameter int WAYS  = `MRD_CACHE_WAYS,
  parameter int LINE  = 16
) (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        lookup,
  input  wire logic [27:0] addr,
  input  wire logic        flush,
  output logic             hit
);

  localparam int SETS = BYTES / (LINE * WAYS);
  localparam int OFFW = $clog2(LINE);
  localparam int IDXW = $clog2(SETS);
  localparam int TAGW = 28 - OFFW - IDXW;

  logic [TAGW-1:0]         tag_q [WAYS][SETS];
  logic [WAYS-1:0]         valid_q [SETS];
  logic [$clog2(WAYS)-1:0] victim_q;
  logic [IDXW-1:0]         set_idx;
  logic [TAGW-1:0]         tag_in;

  assign set_idx = addr[OFFW +: IDXW];
  assign tag_in  = addr[27 -: TAGW];

  always_comb begin
    hit = 1'b0;
    for (int w = 0; w < WAYS; w++) begin
      if (valid_q[set_idx][w] && tag_q[w][set_idx] == tag_in) begin
        hit = 1'b1;
      end
    end
  end

  // Flush on any flash program keeps stale lines from surviving a row update
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int s = 0; s < SETS; s++) begin
        valid_q[s] <= '0;
      end
      victim_q <= '0;
    end else if (flush) begin
      for (int s = 0; s < SETS; s++) begin
        valid_q[s] <= '0;
      end
    end else if (lookup && !hit) begin
      valid_q[set_idx][victim_q] <= 1'b1;
      victim_q                   <= victim_q + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (lookup && !hit && !flush) begin
      tag_q[victim_q][set_idx] <= tag_in;
    end
  end

  property p_fill_hits;
    @(posedge clock) disable iff (!arst_n)
      (lookup && !hit && !flush) ##1 (lookup && !flush && $stable(addr)) |-> hit;
  endproperty
  a_fill_hits: assert property (p_fill_hits) else $error("filled line did not hit");

endmodule
`default_nettype wire

//--- hw/mrd_decoder.sv
/*
  Memory region decoder: routes each master access to its memory, applies
  execute, flash write and lock checks, keeps per-core flash cache tags,
  forwards system call requests and fronts the fuse array.
  Assumes requests come from bus logic on the same clock, one per cycle.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mrd_regs.svh"
module mrd_decoder
  import mrd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        req_valid,
  input  wire logic [31:0] req_addr,
  input  wire mrd_master_t req_master,
  input  wire logic        req_fetch,
  input  wire logic        req_write,
  input  wire logic [2:0]  req_prot_ctx,
  input  wire logic        ultra_low_power_setting,
  input  wire logic        secure_lifecycle,
  input  wire logic [8:0]  sram_block_on,
  input  wire logic [2:0]  sys_call_req,
  input  wire logic        nmi_ack,
  input  wire logic        fuse_prog_req,
  input  wire logic [9:0]  fuse_idx,
  output logic             resp_valid_q,
  output logic             resp_err_q,
  output var mrd_target_t  resp_target_q,
  output logic [15:0]      resp_flash_word_q,
  output logic [3:0]       resp_sram_block_q,
  output logic             resp_cache_hit_q,
  output logic             flash_prog_q,
  output logic [10:0]      flash_row_q,
  output logic             nmi_secondary_q,
  output logic             fuse_bit_q,
  output logic             fuse_sys_area_q
);

  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  mrd_target_t dec_target;
  logic        dec_err;
  logic        is_flash;
  logic        row_aligned;
  logic [3:0]  sram_blk;
  logic [31:0] sram_off;
  logic        hit_main;
  logic        hit_second;
  logic        look_main;
  logic        look_second;
  logic        prog_ok;

  // Window and memory decode
  always_comb begin
    dec_target = MRD_T_ERR;
    if (in_rng(req_addr, `MRD_ROM_LO, `MRD_ROM_HI)) begin
      dec_target = MRD_T_ROM;
    end else if (in_rng(req_addr, `MRD_SRAM_LO, `MRD_SRAM_HI)) begin
      dec_target = MRD_T_SRAM;
    end else if (in_rng(req_addr, `MRD_AFLASH_LO, `MRD_AFLASH_HI)) begin
      dec_target = MRD_T_AFLASH;
    end else if (in_rng(req_addr, `MRD_AUX_LO, `MRD_AUX_HI)) begin
      dec_target = MRD_T_AUX;
    end else if (in_rng(req_addr, `MRD_SUP_LO, `MRD_SUP_HI)) begin
      dec_target = MRD_T_SUP;
    end else if (in_rng(req_addr, `MRD_PERIPH_LO, `MRD_PERIPH_HI)) begin
      dec_target = MRD_T_PERIPH;
    end else if (in_rng(req_addr, `MRD_XRAM_LO, `MRD_XRAM_HI)) begin
      dec_target = MRD_T_XRAM;
    end else if (in_rng(req_addr, `MRD_SYS_LO, `MRD_SYS_HI)) begin
      dec_target = MRD_T_SYS;
    end
    // Holes in the code window and the empty SRAM and device windows fall to error
  end

  assign is_flash    = (dec_target == MRD_T_AFLASH) || (dec_target == MRD_T_AUX) ||
                       (dec_target == MRD_T_SUP);
  assign row_aligned = (req_addr[`MRD_ROW_LSB-1:0] == '0);
  assign sram_off    = req_addr - `MRD_SRAM_LO;
  assign sram_blk    = sram_off[`MRD_SRAM_BLK_LSB +: 4];

  // Access checks
  always_comb begin
    dec_err = (dec_target == MRD_T_ERR);
    if (req_fetch && (dec_target == MRD_T_PERIPH || dec_target == MRD_T_SYS)) begin
      dec_err = 1'b1;
    end
    if (req_fetch && dec_target == MRD_T_ROM &&
        (req_master != MRD_M_SECOND || req_prot_ctx != `MRD_BOOT_CTX)) begin
      dec_err = 1'b1;
    end
    if (req_write && dec_target == MRD_T_ROM) begin
      dec_err = 1'b1;
    end
    if (req_write && is_flash && (ultra_low_power_setting || !row_aligned)) begin
      dec_err = 1'b1;
    end
    if (req_write && dec_target == MRD_T_SUP && secure_lifecycle) begin
      dec_err = 1'b1;
    end
    if (dec_target == MRD_T_SRAM && !sram_block_on[sram_blk]) begin
      dec_err = 1'b1;
    end
  end

  assign prog_ok     = req_valid && req_write && is_flash && !dec_err;
  assign look_main   = req_valid && !req_write && is_flash && !dec_err &&
                       req_master == MRD_M_MAIN;
  assign look_second = req_valid && !req_write && is_flash && !dec_err &&
                       req_master == MRD_M_SECOND;

  // One tag store per core; DMA and debug reads bypass both
  mrd_cache u_cache_main (
    .clock  (clock),
    .arst_n (arst_n),
    .lookup (look_main),
    .addr   (req_addr[27:0]),
    .flush  (prog_ok),
    .hit    (hit_main)
  );

  mrd_cache u_cache_second (
    .clock  (clock),
    .arst_n (arst_n),
    .lookup (look_second),
    .addr   (req_addr[27:0]),
    .flush  (prog_ok),
    .hit    (hit_second)
  );

  // Response, one cycle after the request
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      resp_valid_q      <= 1'b0;
      resp_err_q        <= 1'b0;
      resp_target_q     <= MRD_T_NONE;
      resp_flash_word_q <= '0;
      resp_sram_block_q <= '0;
      resp_cache_hit_q  <= 1'b0;
    end else begin
      resp_valid_q <= req_valid;
      if (req_valid) begin
        resp_err_q        <= dec_err;
        resp_target_q     <= dec_target;
        resp_flash_word_q <= is_flash ? req_addr[`MRD_WORD_LSB +: 16] : 16'h0000;
        resp_sram_block_q <= (dec_target == MRD_T_SRAM) ? sram_blk : 4'h0;
        resp_cache_hit_q  <= (look_main && hit_main) || (look_second && hit_second);
      end else begin
        resp_err_q       <= 1'b0;
        resp_cache_hit_q <= 1'b0;
      end
    end
  end

  // Row program command; the flash engine erases and writes the full row
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flash_prog_q <= 1'b0;
      flash_row_q  <= '0;
    end else begin
      flash_prog_q <= prog_ok;
      if (prog_ok) begin
        flash_row_q <= req_addr[`MRD_ROW_LSB +: 11];
      end
    end
  end

  // System call: a new request wins over an acknowledge in the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      nmi_secondary_q <= 1'b0;
    end else if (|sys_call_req) begin
      nmi_secondary_q <= 1'b1;
    end else if (nmi_ack) begin
      nmi_secondary_q <= 1'b0;
    end
  end

  mrd_fuse u_fuse (
    .clock      (clock),
    .arst_n     (arst_n),
    .prog_req   (fuse_prog_req),
    .idx        (fuse_idx),
    .bit_q      (fuse_bit_q),
    .sys_area_q (fuse_sys_area_q)
  );

  property p_periph_fetch;
    @(posedge clock) disable iff (!arst_n)
      req_valid && req_fetch && req_addr[31:29] == 3'h2 |=> resp_valid_q && resp_err_q;
  endproperty
  a_periph_fetch: assert property (p_periph_fetch) else $error("peripheral fetch not refused");

  property p_asram_empty;
    @(posedge clock) disable iff (!arst_n)
      req_valid && req_addr[31:29] == 3'h1 |=> resp_err_q && resp_target_q == MRD_T_ERR;
  endproperty
  a_asram_empty: assert property (p_asram_empty) else $error("SRAM window answered");

  property p_xram_exec;
    @(posedge clock) disable iff (!arst_n)
      req_valid && req_fetch && !req_write && in_rng(req_addr, `MRD_XRAM_LO, `MRD_XRAM_HI)
      |=> !resp_err_q && resp_target_q == MRD_T_XRAM;
  endproperty
  a_xram_exec: assert property (p_xram_exec) else $error("external RAM fetch refused");

  property p_rom_owner;
    @(posedge clock) disable iff (!arst_n)
      req_valid && req_fetch && req_addr < 32'h0002_0000 && req_master != MRD_M_SECOND
      |=> resp_err_q && resp_target_q == MRD_T_ROM;
  endproperty
  a_rom_owner: assert property (p_rom_owner) else $error("ROM fetch by other master");

  property p_ultra_write;
    @(posedge clock) disable iff (!arst_n)
      req_valid && req_write && ultra_low_power_setting && is_flash
      |=> resp_err_q && !flash_prog_q;
  endproperty
  a_ultra_write: assert property (p_ultra_write) else $error("ultra-low-power write");

  property p_sup_lock;
    @(posedge clock) disable iff (!arst_n)
      req_valid && req_write && secure_lifecycle && req_addr[31:15] == 17'h02C00
      |=> resp_err_q && !flash_prog_q;
  endproperty
  a_sup_lock: assert property (p_sup_lock) else $error("locked sector programmed");

  property p_row_prog;
    @(posedge clock) disable iff (!arst_n)
      req_valid && req_write && !ultra_low_power_setting && req_addr[31:20] == 12'h100 &&
      req_addr[8:0] == 9'h000 |=> flash_prog_q && flash_row_q == $past(req_addr[19:9]);
  endproperty
  a_row_prog: assert property (p_row_prog) else $error("row program missing");

  property p_nmi_hold;
    @(posedge clock) disable iff (!arst_n)
      (|sys_call_req) |=> nmi_secondary_q ##1 (nmi_secondary_q || $past(nmi_ack));
  endproperty
  a_nmi_hold: assert property (p_nmi_hold) else $error("system call NMI lost");

  property p_aflash_word;
    @(posedge clock) disable iff (!arst_n)
      req_valid && !req_write && req_addr[31:20] == 12'h100
      |=> resp_target_q == MRD_T_AFLASH && resp_flash_word_q == $past(req_addr[19:4]);
  endproperty
  a_aflash_word: assert property (p_aflash_word) else $error("flash word index wrong");

  // Fixed addresses, so a slip in the decode chain order shows up here
  property p_rom_map;
    @(posedge clock) disable iff (!arst_n)
      req_valid && req_addr < 32'h0002_0000
      |=> resp_target_q == MRD_T_ROM;
  endproperty
  a_rom_map: assert property (p_rom_map) else $error("ROM not decoded");

  property p_code_data;
    @(posedge clock) disable iff (!arst_n)
      req_valid && !req_fetch && !req_write &&
      req_addr < 32'h0002_0000
      |=> !resp_err_q;
  endproperty
  a_code_data: assert property (p_code_data) else $error("code data read refused");

  property p_sram_map;
    @(posedge clock) disable iff (!arst_n)
      req_valid && in_rng(req_addr, 32'h0800_0000, 32'h0804_7FFF)
      |=> resp_target_q == MRD_T_SRAM;
  endproperty
  a_sram_map: assert property (p_sram_map) else $error("SRAM not decoded");

  property p_block_off;
    @(posedge clock) disable iff (!arst_n)
      req_valid && req_addr[31:18] == 14'h0200 &&
      !sram_block_on[req_addr[17:15]]
      |=> resp_err_q;
  endproperty
  a_block_off: assert property (p_block_off) else $error("powered-off SRAM answered");

  property p_aflash_end;
    @(posedge clock) disable iff (!arst_n)
      req_valid && req_addr[31:20] == 12'h101
      |=> resp_err_q && resp_target_q == MRD_T_ERR;
  endproperty
  a_aflash_end: assert property (p_aflash_end) else $error("flash past its end");

  property p_aux_map;
    @(posedge clock) disable iff (!arst_n)
      req_valid && req_addr[31:15] == 17'h02800
      |=> resp_target_q == MRD_T_AUX;
  endproperty
  a_aux_map: assert property (p_aux_map) else $error("auxiliary sector not decoded");

  property p_sup_map;
    @(posedge clock) disable iff (!arst_n)
      req_valid && req_addr[31:15] == 17'h02C00
      |=> resp_target_q == MRD_T_SUP;
  endproperty
  a_sup_map: assert property (p_sup_map) else $error("supervisory sector not decoded");

  property p_xdev_err;
    @(posedge clock) disable iff (!arst_n)
      req_valid &&
      req_addr[31:29] inside {3'h5, 3'h6}
      |=> resp_err_q && resp_target_q == MRD_T_ERR;
  endproperty
  a_xdev_err: assert property (p_xdev_err) else $error("device window answered");

  property p_rom_write;
    @(posedge clock) disable iff (!arst_n)
      req_valid && req_write &&
      req_addr < 32'h0002_0000
      |=> resp_err_q && !flash_prog_q;
  endproperty
  a_rom_write: assert property (p_rom_write) else $error("ROM write accepted");

  property p_own_cache;
    @(posedge clock) disable iff (!arst_n)
      req_valid &&
      (req_master == MRD_M_DMA || req_master == MRD_M_DEBUG)
      |=> !resp_cache_hit_q;
  endproperty
  a_own_cache: assert property (p_own_cache) else $error("uncached master hit");

  property p_resp_pulse;
    @(posedge clock) disable iff (!arst_n)
      !req_valid
      |=> !resp_valid_q && !resp_err_q;
  endproperty
  a_resp_pulse: assert property (p_resp_pulse) else $error("answer without request");

  c_cache_hit: cover property (@(posedge clock) disable iff (!arst_n) resp_cache_hit_q);
  c_flash_prog: cover property (@(posedge clock) disable iff (!arst_n) flash_prog_q);
  c_nmi: cover property (@(posedge clock) disable iff (!arst_n) $rose(nmi_secondary_q));
  c_err: cover property (@(posedge clock) disable iff (!arst_n) resp_err_q);
  c_rom_boot: cover property (@(posedge clock) disable iff (!arst_n)
    resp_target_q == MRD_T_ROM && !resp_err_q && $past(req_fetch));

endmodule
`default_nettype wire

//--- sim/mrd_master_model.sv
/*
  Bus master model: the cores, DMA and debug port that issue decoder
  requests, plus the secondary core's answer to the system call NMI.
  Assumes its tasks are called at the falling clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module mrd_master_model
  import mrd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nmi_secondary_q,
  output logic             req_valid,
  output logic [31:0]      req_addr,
  output var mrd_master_t  req_master,
  output logic             req_fetch,
  output logic             req_write,
  output logic [2:0]       req_prot_ctx,
  output logic [2:0]       sys_call_req,
  output logic             nmi_ack
);
  int ack_delay = 1;
  int wait_cnt  = 0;

  initial begin
    req_valid    = 1'b0;
    req_addr     = 32'h0000_0000;
    req_master   = MRD_M_MAIN;
    req_fetch    = 1'b0;
    req_write    = 1'b0;
    req_prot_ctx = 3'h0;
    sys_call_req = 3'h0;
    nmi_ack      = 1'b0;
  end

  task automatic issue(input logic [31:0] a, input logic [1:0] m, input logic f, w,
                       input logic [2:0] c);
    req_valid    = 1'b1;
    req_addr     = a;
    req_master   = mrd_master_t'(m);
    req_fetch    = f;
    req_write    = w;
    req_prot_ctx = c;
  endtask

  // Released bus shows the inverse, so a stale address never looks held
  task automatic idle();
    req_valid = 1'b0;
    req_addr  = ~req_addr;
    req_fetch = ~req_fetch;
    req_write = ~req_write;
  endtask

  task automatic sys_call(input int idx, input logic on);
    sys_call_req = on ? (3'h1 << idx) : 3'h0;
  endtask

  // Secondary core acknowledges after a settable delay, prompt or slow
  always @(negedge clock) begin
    if (nmi_secondary_q && wait_cnt >= ack_delay) begin
      nmi_ack  <= 1'b1;
      wait_cnt <= 0;
    end else begin
      nmi_ack  <= 1'b0;
      wait_cnt <= nmi_secondary_q ? wait_cnt + 1 : 0;
    end
  end
endmodule
`default_nettype wire

//--- sim/testbench.sv
/*
  Self-checking bench of the memory region decoder against a reference model.
  Assumes the decoder answers one cycle after each request edge.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import mrd_pkg::*;
  logic             clock                   = 1'b0;
  logic             arst_n                  = 1'b0;
  logic             ultra_low_power_setting = 1'b0;
  logic             secure_lifecycle        = 1'b0;
  logic [8:0]       sram_block_on           = 9'h1FF;
  logic             fuse_prog_req           = 1'b0;
  logic [9:0]       fuse_idx                = 10'h000;
  logic             req_valid, req_fetch, req_write, nmi_ack, nmi_secondary_q;
  logic             resp_valid_q, resp_err_q, resp_cache_hit_q, flash_prog_q;
  logic             fuse_bit_q, fuse_sys_area_q;
  logic [31:0]      req_addr;
  logic [2:0]       req_prot_ctx, sys_call_req;
  mrd_master_t      req_master;
  mrd_target_t      resp_target_q;
  logic [15:0]      resp_flash_word_q;
  logic [3:0]       resp_sram_block_q;
  logic [10:0]      flash_row_q;
  logic [1023:0]    fuse_m = '0;
  logic [9:0]       fuse_tab [5] = '{10'h000, 10'h1FF, 10'h200, 10'h3FF, 10'h155};
  logic [31:0]      addr_tab [23] = '{32'h0000_0000, 32'h0001_FFFC, 32'h0002_0000,
    32'h0800_0000, 32'h0801_8000, 32'h0804_7FFC, 32'h0804_8000, 32'h1000_0000,
    32'h100F_FE00, 32'h100F_FFF0, 32'h1010_0000, 32'h1400_7E00, 32'h1400_8000,
    32'h1600_0000, 32'h1600_7FF0, 32'h2000_0000, 32'h4000_0000, 32'h5FFF_FFFC,
    32'h6000_0000, 32'h9FFF_FFFC, 32'hA000_0000, 32'hDFFF_FFFC, 32'hE000_0000};
  int               failures  = 0;
  int               tests_run = 0;
  int               exp_hit   = -1;
  int               seed_void;

  always #10 clock = ~clock;

  mrd_decoder u_mrd_decoder (.clock, .arst_n, .req_valid, .req_addr, .req_master,
    .req_fetch, .req_write, .req_prot_ctx, .ultra_low_power_setting, .secure_lifecycle,
    .sram_block_on, .sys_call_req, .nmi_ack, .fuse_prog_req, .fuse_idx, .resp_valid_q,
    .resp_err_q, .resp_target_q, .resp_flash_word_q, .resp_sram_block_q,
    .resp_cache_hit_q, .flash_prog_q, .flash_row_q, .nmi_secondary_q, .fuse_bit_q,
    .fuse_sys_area_q);

  mrd_master_model u_mrd_master_model (.clock, .nmi_secondary_q, .req_valid, .req_addr,
    .req_master, .req_fetch, .req_write, .req_prot_ctx, .sys_call_req, .nmi_ack);

  task automatic chk(input bit ok, input string what);
    tests_run++;
    if (!ok) begin
      failures++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask

  task automatic results();
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic void ref_model(input logic [31:0] a, input int m, f, w, c,
                                    output int err, output mrd_target_t tgt);
    err = 0;
    tgt = MRD_T_ERR;
    if (a <= 32'h0001_FFFF) begin
      tgt = MRD_T_ROM;
      err = (w != 0 || (f != 0 && !(m == 1 && c == 0))) ? 1 : 0;
    end else if (a >= 32'h0800_0000 && a <= 32'h0804_7FFF) begin
      tgt = MRD_T_SRAM;
      err = sram_block_on[(a - 32'h0800_0000) >> 15] ? 0 : 1;
    end else if (a >= 32'h1000_0000 && a <= 32'h100F_FFFF) tgt = MRD_T_AFLASH;
    else if (a >= 32'h1400_0000 && a <= 32'h1400_7FFF) tgt = MRD_T_AUX;
    else if (a >= 32'h1600_0000 && a <= 32'h1600_7FFF) tgt = MRD_T_SUP;
    else if (a < 32'h4000_0000 || (a >= 32'hA000_0000 && a < 32'hE000_0000)) err = 1;
    else if (a < 32'h6000_0000) tgt = MRD_T_PERIPH;
    else if (a < 32'hA000_0000) tgt = MRD_T_XRAM;
    else tgt = MRD_T_SYS;
    if (tgt == MRD_T_PERIPH || tgt == MRD_T_SYS) err = f;
    if ((tgt == MRD_T_AFLASH || tgt == MRD_T_AUX || tgt == MRD_T_SUP) && w != 0) begin
      err = (ultra_low_power_setting || a[8:0] != 9'h000) ? 1 : 0;
      if (tgt == MRD_T_SUP && secure_lifecycle) err = 1;
    end
  endfunction

  // One request, taken at the next rising edge, answer checked a half cycle later
  task automatic access(input logic [31:0] a, input int m, f, w, c);
    int          err;
    mrd_target_t tgt;
    bit          fl;
    ref_model(a, m, f, w, c, err, tgt);
    u_mrd_master_model.issue(a, m[1:0], f[0], w[0], c[2:0]);
    @(posedge clock);
    @(negedge clock);
    fl = (tgt == MRD_T_AFLASH || tgt == MRD_T_AUX || tgt == MRD_T_SUP) && err == 0;
    chk(resp_valid_q === 1'b1, "no answer");
    chk(resp_err_q === (err != 0), "error flag");
    if (err == 0 || tgt == MRD_T_ERR) chk(resp_target_q === tgt, "target");
    chk(flash_prog_q === (fl && w != 0), "row program");
    if (fl && w != 0) chk(flash_row_q === a[19:9], "row index");
    if (fl) chk(resp_flash_word_q === a[19:4], "flash word");
    if (tgt == MRD_T_SRAM && err == 0)
      chk(resp_sram_block_q === 4'((a - 32'h0800_0000) >> 15), "sram block");
    if (exp_hit >= 0) chk(resp_cache_hit_q === exp_hit[0], "cache hit");
  endtask

  task automatic fuse_read(input logic [9:0] idx);
    fuse_idx = idx;
    @(posedge clock);
    @(negedge clock);
    chk(fuse_bit_q === fuse_m[idx], "fuse value");
    chk(fuse_sys_area_q === (idx < 10'h200), "fuse system area");
  endtask

  task automatic fuse_prog(input logic [9:0] idx);
    fuse_idx      = idx;
    fuse_prog_req = 1'b1;
    @(posedge clock);
    @(negedge clock);
    fuse_prog_req = 1'b0;
    fuse_m[idx]   = 1'b1;
  endtask

  task automatic do_reset(input int n);
    arst_n = 1'b0;
    repeat (n) @(negedge clock);
    chk(resp_valid_q === 1'b0 && resp_target_q === MRD_T_NONE, "reset outputs");
    chk(nmi_secondary_q === 1'b0 && flash_prog_q === 1'b0, "reset pulses");
    arst_n = 1'b1;
    fuse_m = '0;
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    chk(1'b0, "run did not finish");
    results();
  end

  initial begin
    int          n;
    logic [31:0] r;
    seed_void = $urandom(45);
    fuse_tab[4] = 10'($urandom);
    do_reset(16);
    sram_block_on = 9'h1F7;
    for (int p = 0; p < 3; p++) begin
      ultra_low_power_setting = (p == 1);
      secure_lifecycle        = (p == 2);
      foreach (addr_tab[k]) begin
        for (int i = 0; i < 64; i++) begin
          if (!(i[2] && i[3])) access(addr_tab[k], i % 4, i[2], i[3], i / 16);
        end
      end
    end
    for (int k = 0; k < 300; k++) begin
      sram_block_on           = 9'($urandom);
      ultra_low_power_setting = 1'($urandom);
      secure_lifecycle        = 1'($urandom);
      r = $urandom;
      n = r[0] ? 32'h0003_FE00 : 32'h0003_FFFF;
      access(addr_tab[$urandom % 23] ^ ($urandom & n), r[5:4], r[2], r[3] & ~r[2], r[8:6]);
    end
    u_mrd_master_model.idle();
    @(posedge clock);
    @(negedge clock);
    chk(resp_valid_q === 1'b0 && resp_err_q === 1'b0, "answer without request");
    ultra_low_power_setting = 1'b0;
    secure_lifecycle        = 1'b0;
    access(32'h1000_0200, 0, 0, 1, 0);
    exp_hit = 0;
    access(32'h1000_0040, 0, 0, 0, 0);
    exp_hit = 1;
    access(32'h1000_0040, 0, 0, 0, 0);
    exp_hit = 0;
    access(32'h1000_0040, 1, 0, 0, 0);
    access(32'h1000_0040, 2, 0, 0, 0);
    // Four lines of one set all stay resident in a four-way cache
    for (int p = 0; p < 8; p++) begin
      exp_hit = p / 4;
      access(32'h1000_1000 + 32'(p % 4) * 32'h0000_0800, 0, 0, 0, 0);
    end
    exp_hit = -1;
    access(32'h1400_0000, 1, 0, 1, 0);
    exp_hit = 0;
    access(32'h1000_0040, 0, 0, 0, 0);
    exp_hit = -1;
    u_mrd_master_model.idle();
    for (int b = 0; b < 3; b++) begin
      u_mrd_master_model.ack_delay = (b == 0) ? 1 : 6;
      u_mrd_master_model.sys_call(b, 1'b1);
      @(posedge clock);
      @(negedge clock);
      chk(nmi_secondary_q === 1'b1, "nmi not raised");
      repeat (8) @(negedge clock);
      chk(nmi_secondary_q === 1'b1, "nmi dropped while requested");
      u_mrd_master_model.sys_call(b, 1'b0);
      n = 0;
      while (nmi_secondary_q !== 1'b0 && n < 20) begin
        @(negedge clock);
        n++;
      end
      chk(n < 20, "nmi never cleared");
      if (n >= 20) results();
    end
    foreach (fuse_tab[k]) begin
      fuse_read(fuse_tab[k]);
      fuse_prog(fuse_tab[k]);
      fuse_read(fuse_tab[k]);
      fuse_read(fuse_tab[k] ^ 10'h001);
    end
    fuse_prog(fuse_tab[0]);
    fuse_read(fuse_tab[0]);
    do_reset(3);
    fuse_read(fuse_tab[1]);
    results();
  end
endmodule
`default_nettype wire
